/* File: src/fbcd_host.sv */
// Host controller that drives a multiplexed flash bus through its pins.
//
// Functional notes
// R1 - Strobe pulses always longer than 5 ns.
// R2 - Command: CE low, CL high, AL low.
// R3 - Command bytes use low eight lines only.
// R4 - Four or five address cycles by density.
// R5 - Address: CE low, AL high, CL low.
// R6 - Data in: latches low, WP high.
// R7 - Data out on read strobe falling edges.
// R8 - Output content depends on prior command.
// R9 - Low write protect blocks program, erase.
// R10 - Host holds write protect high; here WP_N follows REQ_WP_EN and is low from reset.
// R11 - Chip enable high means standby.
// R12 - Word parts use all sixteen lines.
// R13 - Extra address cycles are ignored.
// R14 - Byte-wide address cycle packing.
// R15 - Byte-wide fifth cycle uses density bits.
// R16 - Word-wide address cycle packing.
// R17 - Word-wide fifth cycle uses density bits.
// R18 - Byte-wide column, page, block split.
// R19 - Word-wide column, page, block split.
// R20 - Each read strobe advances column.
// R21 - Busy device stays selected after CE.
// R22 - Undefined control mixes are never driven.
`timescale 1ns/1ps
module fbcd_host
  import fbcd_pkg::*;
#(
  parameter int          FIFO_DEPTH = 32,            // Read data FIFO depth.
  parameter logic [2:0]  DENSITY    = DENS_8G,       // Part density code.
  parameter bit          WORD_WIDE  = 1'b0           // Sixteen-bit part.
) (
  input  wire logic              CLK,                // Clock, 100 MHz.
  input  wire logic              RST_N,              // Async reset, low.
  input  wire logic              REQ_VALID,          // Request present.
  output logic                   REQ_READY,          // Request taken.
  input  wire logic [1:0]        REQ_OP,             // fbcd_pkg::OP_* code.
  input  wire logic [7:0]        REQ_CMD,            // Command byte.
  input  wire logic [30:0]       REQ_ADDR,           // Flat address.
  input  wire logic [15:0]       REQ_WDATA,          // Program word.
  input  wire logic [7:0]        REQ_LEN,            // Read words minus 1.
  input  wire logic              REQ_WP_EN,          // Keep write enabled.
  output logic [15:0]            RD_DATA,            // Read word.
  output logic                   RD_VALID,           // Read word valid.
  input  wire logic              RD_READY,           // Read word taken.
  output logic                   CE_N,               // Chip enable, low.
  output logic                   CMD_LATCH_STROBE,   // Command latch.
  output logic                   ADDR_LATCH_STROBE,  // Address latch.
  output logic                   WE_N,               // Write strobe, low.
  output logic                   RE_N,               // Read strobe, low.
  output logic                   WP_N,               // Write protect, low.
  output logic [15:0]            IO_OUT,             // Bus drive value.
  output logic                   IO_OE,              // Bus drive enable.
  input  wire logic [15:0]       IO_IN,              // Bus sampled value.
  output logic                   BUSY                // Host cycle active.
);

  // ****************************************************************
  // Address packing helpers.
  // ****************************************************************

  // Byte of address cycle n, packed the way the part expects.
  function automatic logic [7:0] addr_byte(input logic [30:0] a,
                                           input logic [2:0]  n);
    logic [7:0] b;
    b = 8'h00;
    if (!WORD_WIDE) begin
      unique case (n)
        3'h0: b = a[7:0];                                 // [R14] [R18]
        3'h1: b = {4'h0, a[11:8]};                        // [R14]
        3'h2: b = a[19:12];                               // [R14] [R18]
        3'h3: b = a[27:20];                               // [R14]
        default: b = {5'h00, a[30:28] & fifth_mask()};    // [R15]
      endcase
    end else begin
      unique case (n)
        3'h0: b = a[7:0];                                 // [R16] [R19]
        3'h1: b = {5'h00, a[10:8]};                       // [R16]
        3'h2: b = a[18:11];                               // [R16] [R19]
        3'h3: b = a[26:19];                               // [R16]
        default: b = {5'h00, a[29:27] & fifth_mask()};    // [R17]
      endcase
    end
    return b;
  endfunction

  // Fifth-cycle bits that the chosen density really decodes.
  function automatic logic [2:0] fifth_mask();
    logic [2:0] m;
    m = 3'h0;
    if (DENSITY == DENS_2G) begin
      m = 3'h1;
    end else if (DENSITY == DENS_4G) begin
      m = 3'h3;
    end else if (DENSITY == DENS_8G) begin
      m = 3'h7;
    end
    return m;
  endfunction

  // Short parts take four cycles, larger ones five; none extra sent.
  localparam logic [2:0] ADDR_CYCLES =
    (DENSITY == DENS_512M || DENSITY == DENS_1G) ?
    ADDR_CYC_SHORT : ADDR_CYC_LONG;                       // [R4] [R13]

  // ****************************************************************
  // State and captured request.
  // ****************************************************************
  fbcd_state_t state_q;                              // Bus sequencer state.
  logic [1:0]  op_q;                                 // Operation in flight.
  logic [7:0]  cmd_q;                                // Command byte.
  logic [30:0] addr_q;                               // Address held.
  logic [15:0] wdata_q;                              // Program word.
  logic [7:0]  left_q;                               // Cycles remaining.
  logic [2:0]  acyc_q;                               // Address cycle index.
  logic [3:0]  tim_q;                                // Phase timer.
  logic [15:0] fifo_in;                              // Captured read word.
  logic        fifo_push;                            // Capture strobe.
  logic        fifo_rdy;                             // FIFO has room.
  logic [15:0] fifo_out;                             // FIFO head.
  logic        fifo_vld;                             // FIFO not empty.

  // Read words are captured as the read strobe rises again: the first
  // high-phase cycle is the only one in which the pin is still low.
  assign fifo_push = (state_q == FBCD_HIGH) && (op_q == OP_RD) &&
                     (RE_N == 1'b0);
  assign fifo_in   = WORD_WIDE ? IO_IN : {8'h00, IO_IN[7:0]};  // [R12]

  // The data FIFO stands between the pin sampler and the user.
  fbcd_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_data   (fifo_in),
    .in_valid  (fifo_push),
    .in_ready  (fifo_rdy),
    .out_data  (fifo_out),
    .out_valid (fifo_vld),
    .out_ready (RD_READY && RD_VALID)
  );

  // Registered FIFO output keeps the top outputs flop-driven.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_VALID <= 1'b0;
      RD_DATA  <= 16'h0000;
    end else if (!RD_VALID || RD_READY) begin
      RD_VALID <= fifo_vld && !(RD_VALID && RD_READY);
      RD_DATA  <= fifo_out;
    end
  end

  // ****************************************************************
  // Bus sequencer.
  // ****************************************************************

  // Each bus cycle: set levels, hold the strobe low, then high. A read
  // word waits in LOW while the FIFO is full, so back-pressure stalls the
  // pins rather than losing data.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= FBCD_IDLE;
      tim_q   <= 4'h0;
      op_q    <= OP_CMD;
      cmd_q   <= 8'h00;
      addr_q  <= '0;
      wdata_q <= 16'h0000;
      left_q  <= 8'h00;
      acyc_q  <= 3'h0;
    end else begin
      unique case (state_q)
        FBCD_IDLE: begin
          if (REQ_VALID && REQ_READY) begin
            op_q    <= REQ_OP;
            cmd_q   <= REQ_CMD;
            addr_q  <= REQ_ADDR;
            wdata_q <= REQ_WDATA;
            left_q  <= (REQ_OP == OP_RD) ? REQ_LEN : 8'h00;
            acyc_q  <= 3'h0;
            tim_q   <= 4'h1;
            state_q <= FBCD_SETUP;
          end
        end
        FBCD_SETUP: begin
          tim_q   <= 4'h1;
          state_q <= FBCD_LOW;
        end
        FBCD_LOW: begin
          // Hold the low phase at least the glitch-proof width.
          if (tim_q >= STROBE_LOW_CYC &&
              (op_q != OP_RD || fifo_rdy)) begin        // [R1]
            tim_q   <= 4'h1;
            state_q <= FBCD_HIGH;
          end else if (tim_q < STROBE_LOW_CYC) begin
            tim_q <= tim_q + 4'h1;
          end
        end
        FBCD_HIGH: begin
          if (tim_q >= STROBE_HIGH_CYC) begin           // [R1]
            state_q <= FBCD_NEXT;
          end else begin
            tim_q <= tim_q + 4'h1;
          end
        end
        FBCD_NEXT: begin
          // Address repeats until the count; reads repeat per word.
          if (op_q == OP_ADDR && acyc_q + 3'h1 < ADDR_CYCLES) begin
            acyc_q  <= acyc_q + 3'h1;                   // [R4]
            tim_q   <= 4'h1;
            state_q <= FBCD_LOW;
          end else if (op_q == OP_RD && left_q != 8'h00) begin
            left_q  <= left_q - 8'h01;                  // [R20]
            tim_q   <= 4'h1;
            state_q <= FBCD_LOW;
          end else begin
            state_q <= FBCD_IDLE;
          end
        end
        default: state_q <= FBCD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Pin drivers, all registered.
  // ****************************************************************

  // Control levels follow the operation; only legal mixes are formed.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CE_N              <= 1'b1;
      CMD_LATCH_STROBE  <= 1'b0;
      ADDR_LATCH_STROBE <= 1'b0;
      WE_N              <= 1'b1;
      RE_N              <= 1'b1;
      IO_OUT            <= 16'h0000;
      IO_OE             <= 1'b0;
      BUSY              <= 1'b0;
    end else begin
      BUSY <= (state_q != FBCD_IDLE);
      if (state_q == FBCD_IDLE) begin
        // Deselect between requests; the part may stay busy inside.
        CE_N              <= 1'b1;                      // [R11] [R21]
        CMD_LATCH_STROBE  <= 1'b0;
        ADDR_LATCH_STROBE <= 1'b0;
        WE_N              <= 1'b1;
        RE_N              <= 1'b1;
        IO_OE             <= 1'b0;
      end else begin
        CE_N              <= 1'b0;
        CMD_LATCH_STROBE  <= (op_q == OP_CMD);          // [R2] [R22]
        ADDR_LATCH_STROBE <= (op_q == OP_ADDR);         // [R5] [R22]
        IO_OE             <= (op_q != OP_RD);
        if (op_q == OP_RD) begin
          WE_N <= 1'b1;                                 // [R7]
          RE_N <= (state_q != FBCD_LOW);                // [R7] [R8]
        end else begin
          RE_N <= 1'b1;                                 // [R2] [R5] [R6]
          WE_N <= (state_q != FBCD_LOW);
        end
        unique case (op_q)
          OP_CMD:  IO_OUT <= {8'h00, cmd_q};            // [R3]
          OP_ADDR: IO_OUT <= {8'h00, addr_byte(addr_q, acyc_q)};
          OP_WR:   IO_OUT <= WORD_WIDE ? wdata_q :
                             {8'h00, wdata_q[7:0]};     // [R6] [R12]
          default: IO_OUT <= IO_OUT;
        endcase
      end
    end
  end

  // Write protect is held high only while the user enables writes.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      WP_N <= 1'b0;                                     // [R9]
    end else begin
      WP_N <= REQ_WP_EN;                                // [R10] [R6]
    end
  end

  // Requests are taken only in idle with the previous cycle finished.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REQ_READY <= 1'b0;
    end else begin
      REQ_READY <= (state_q == FBCD_IDLE) && !(REQ_VALID && REQ_READY);
    end
  end

endmodule

/* File: src/fbcd_pkg.sv */
// Package of constants and types for the flash bus-cycle host controller.
package fbcd_pkg;

  // ****************************************************************
  // Timing constants.
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 10;                // Clock period in ns.
  localparam int GLITCH_MIN_NS  = 5;                 // Least strobe pulse.
  // Least time rounds up to whole cycles, never below one.
  localparam int STROBE_CYC_RAW = (GLITCH_MIN_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam int STROBE_CYC     = (STROBE_CYC_RAW < 1) ? 1 : STROBE_CYC_RAW;
  localparam logic [3:0] STROBE_LOW_CYC  = 4'(STROBE_CYC + 1); // Low phase.
  localparam logic [3:0] STROBE_HIGH_CYC = 4'(STROBE_CYC + 1); // High phase.

  // ****************************************************************
  // Density codes and address cycle counts.
  // ****************************************************************
  localparam logic [2:0] DENS_512M = 3'h0;           // 512 Mbit part.
  localparam logic [2:0] DENS_1G   = 3'h1;           // 1 Gbit part.
  localparam logic [2:0] DENS_2G   = 3'h2;           // 2 Gbit part.
  localparam logic [2:0] DENS_4G   = 3'h3;           // 4 Gbit part.
  localparam logic [2:0] DENS_8G   = 3'h4;           // 8 Gbit part.
  localparam logic [2:0] ADDR_CYC_SHORT = 3'h4;      // Four cycles.
  localparam logic [2:0] ADDR_CYC_LONG  = 3'h5;      // Five cycles.

  // ****************************************************************
  // Address field positions (byte-wide and word-wide).
  // ****************************************************************
  localparam int COL_W_X8   = 12;                    // Column A0-A11.
  localparam int COL_W_X16  = 11;                    // Column A0-A10.
  localparam int PAGE_W     = 6;                     // Page field width.
  localparam int BLK_MSB_X8 = 26;                    // Block top, 512Mb x8.
  localparam int BLK_MSB_X16 = 25;                   // Block top, 512Mb x16.
  localparam int ADDR_W     = 31;                    // Flat address width.

  // ****************************************************************
  // Host command opcodes on the user port.
  // ****************************************************************
  localparam logic [1:0] OP_CMD  = 2'h0;             // Command byte.
  localparam logic [1:0] OP_ADDR = 2'h1;             // Full address.
  localparam logic [1:0] OP_WR   = 2'h2;             // Program data word.
  localparam logic [1:0] OP_RD   = 2'h3;             // Read data words.

  // Bus controller states, one-hot.
  typedef enum logic [4:0] {
    FBCD_IDLE  = 5'b00001,                           // Standby, chip off.
    FBCD_SETUP = 5'b00010,                           // Levels settle.
    FBCD_LOW   = 5'b00100,                           // Strobe low phase.
    FBCD_HIGH  = 5'b01000,                           // Strobe high phase.
    FBCD_NEXT  = 5'b10000                            // Pick next cycle.
  } fbcd_state_t;

endpackage

/* File: src/fbcd_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module fbcd_fifo #(
  parameter int WIDTH = 16,                          // Word width.
  parameter int DEPTH = 32                           // Word count.
) (
  input  wire logic             clk,                 // Clock.
  input  wire logic             rst_n,               // Async reset, low.
  input  wire logic [WIDTH-1:0] in_data,             // Write word.
  input  wire logic             in_valid,            // Write request.
  output logic                  in_ready,            // Not full.
  output logic      [WIDTH-1:0] out_data,            // Head word.
  output logic                  out_valid,           // Not empty.
  input  wire logic             out_ready            // Drain accept.
);
  localparam int AW = $clog2(DEPTH);                 // Pointer width.

  logic [WIDTH-1:0] mem [DEPTH];                     // Storage array.
  logic [AW-1:0]    wr_q;                            // Write pointer.
  logic [AW-1:0]    rd_q;                            // Read pointer.
  logic [AW:0]      cnt_q;                           // Fill count.
  logic             push;                            // Accepted write.
  logic             pop;                             // Accepted read.

  // Full and empty come straight from the fill count.
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is not reset; only the pointers and the fill count carry state.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers wrap naturally since depth is a power of two.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

/* File: tb/fbcd_monitor.sv */
// Checker of the pin sequencing that the flash host drives.
`timescale 1ns/1ps
module fbcd_monitor (
  input wire logic        CLK,               // Clock.
  input wire logic        RST_N,             // Reset, active low.
  input wire logic        CE_N,              // Chip enable.
  input wire logic        CMD_LATCH_STROBE,  // Command latch.
  input wire logic        ADDR_LATCH_STROBE, // Address latch.
  input wire logic        WE_N,              // Write strobe.
  input wire logic        RE_N,              // Read strobe.
  input wire logic        WP_N,              // Write protect.
  input wire logic        IO_OE,             // Bus drive enable.
  input wire logic        REQ_WP_EN,         // Protect release request.
  input wire logic        RD_VALID,          // Read word valid.
  input wire logic        RD_READY,          // Read word taken.
  input wire logic [15:0] RD_DATA            // Read word.
);
  // ****************************************************************
  // Clocking and strobe shapes.
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // A write pulse is two cycles low, then two high, far above 5 ns.
  sequence s_we_pulse;
    !WE_N [*2] ##1 WE_N [*2];
  endsequence
  // A read low phase may stretch under back-pressure, never shrink.
  sequence s_re_low;
    !RE_N [*2];
  endsequence

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_we_pulse_width: assert property (
    $fell(WE_N) |-> s_we_pulse) else $error("write strobe pulse short");
  a_re_pulse_width: assert property (
    $fell(RE_N) |-> s_re_low) else $error("read strobe pulse short");
  a_cmd_levels: assert property (
    $rose(WE_N) && CMD_LATCH_STROBE |-> !CE_N && !ADDR_LATCH_STROBE && RE_N)
    else $error("command cycle levels wrong");
  a_addr_levels: assert property (
    $rose(WE_N) && ADDR_LATCH_STROBE |-> !CE_N && !CMD_LATCH_STROBE && RE_N)
    else $error("address cycle levels wrong");
  a_write_levels: assert property (
    $rose(WE_N) |-> !CE_N && RE_N) else $error("write cycle levels wrong");
  a_read_levels: assert property (
    $fell(RE_N) |-> !CE_N && WE_N && !CMD_LATCH_STROBE && !ADDR_LATCH_STROBE)
    else $error("read cycle levels wrong");
  a_latch_exclusive: assert property (
    !(CMD_LATCH_STROBE && ADDR_LATCH_STROBE)) else $error("both latches high");
  a_write_drive: assert property (
    !WE_N |-> IO_OE) else $error("bus undriven in write");
  a_read_float: assert property (
    !RE_N |-> !IO_OE) else $error("bus driven in read");
  a_standby_quiet: assert property (
    CE_N |-> WE_N && RE_N) else $error("strobe while deselected");
  a_wp_follow: assert property (
    $past(RST_N) |-> WP_N == $past(REQ_WP_EN))
    else $error("protect level lags");
  a_rd_hold: assert property (
    RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_DATA))
    else $error("read word dropped");
endmodule

bind fbcd_host fbcd_monitor fbcd_monitor_inst (
  .CLK(CLK), .RST_N(RST_N), .CE_N(CE_N), .CMD_LATCH_STROBE(CMD_LATCH_STROBE),
  .ADDR_LATCH_STROBE(ADDR_LATCH_STROBE), .WE_N(WE_N), .RE_N(RE_N),
  .WP_N(WP_N), .IO_OE(IO_OE), .REQ_WP_EN(REQ_WP_EN), .RD_VALID(RD_VALID),
  .RD_READY(RD_READY), .RD_DATA(RD_DATA));

/* File: tb/fbcd_flash_model.sv */
// Behavioural model of a byte-wide flash part on the far side of the bus.
`timescale 1ns/1ps
module fbcd_flash_model (
  input wire logic        ce_n,    // Chip enable, low.
  input wire logic        cl,      // Command latch strobe.
  input wire logic        al,      // Address latch strobe.
  input wire logic        we_n,    // Write strobe.
  input wire logic        re_n,    // Read strobe.
  input wire logic        wp_n,    // Write protect, low.
  input wire logic [15:0] io_bus,  // Resolved bus level.
  output logic     [15:0] dev_q,   // Value the part drives.
  output logic            dev_oe   // Part drives the bus.
);
  logic [7:0]  cmd_q    = 8'h00;   // Last command byte.
  logic [39:0] addr_q   = '0;      // Captured address bytes.
  logic [2:0]  acnt     = 3'h0;    // Address cycles taken.
  logic [7:0]  prog_q   = 8'h00;   // Last program byte.
  int          prog_cnt = 0;       // Program bytes accepted.
  logic [11:0] col      = 12'h000; // Column counter.
  initial dev_q = 16'h0000;
  // Outputs only while selected and reading; standby floats the bus.
  assign dev_oe = !ce_n && !re_n && we_n && !cl && !al;
  // Bus inputs latch on write strobe rising edges; mixed latches do nothing.
  always @(posedge we_n) begin
    if (!ce_n) begin
      if (cl && !al && re_n) begin
        cmd_q <= io_bus[7:0];
        acnt  <= 3'h0;
      end else if (al && !cl && re_n) begin
        if (acnt < 3'h5) begin
          addr_q[8*acnt +: 8] <= io_bus[7:0];
          acnt <= acnt + 3'h1;
        end
        // Column is A11..A0 of the first two cycles.
        if (acnt == 3'h1) col <= {io_bus[3:0], addr_q[7:0]};
      end else if (!al && !cl && re_n && wp_n) begin
        prog_q   <= io_bus[7:0];
        prog_cnt <= prog_cnt + 1;
      end
    end
  end
  // Each falling read strobe yields a word and advances the column.
  always @(negedge re_n) begin
    if (!ce_n && we_n && !cl && !al) begin
      dev_q <= {~(col[7:0] ^ 8'ha5), col[7:0] ^ 8'ha5};
      col   <= col + 12'h001;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking testbench for the flash bus host controller.
`timescale 1ns/1ps
module tb_top;
  import fbcd_pkg::*;
  logic        clk = 0, rst_n = 0, req_valid = 0, rd_ready = 0;
  logic        req_wp_en = 0, req_ready, rd_valid, ce_n, cl, al, we_n;
  logic        re_n, wp_n, io_oe, busy, dev_oe;
  logic [1:0]  req_op = 2'h0;
  logic [7:0]  req_cmd = 8'h00, req_len = 8'h00;
  logic [30:0] req_addr = '0;
  logic [15:0] req_wdata = 16'h0000, rd_data, io_out, io_in, dev_q;
  int          fails = 0, samples_checked = 0, cycles = 0;
  localparam logic [30:0] ADR = 31'h7edc_ba98; // Test address.

  always #5 clk = ~clk;
  // Released bus shows the inverse of the part's last output value.
  assign io_in = io_oe ? io_out : (dev_oe ? dev_q : ~dev_q);

  fbcd_host fbcd_host_inst (
    .CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ_READY(req_ready),
    .REQ_OP(req_op), .REQ_CMD(req_cmd), .REQ_ADDR(req_addr),
    .REQ_WDATA(req_wdata), .REQ_LEN(req_len), .REQ_WP_EN(req_wp_en),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_READY(rd_ready), .CE_N(ce_n),
    .CMD_LATCH_STROBE(cl), .ADDR_LATCH_STROBE(al), .WE_N(we_n), .RE_N(re_n),
    .WP_N(wp_n), .IO_OUT(io_out), .IO_OE(io_oe), .IO_IN(io_in), .BUSY(busy));
  fbcd_flash_model fbcd_flash_model_inst (
    .ce_n(ce_n), .cl(cl), .al(al), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .io_bus(io_in), .dev_q(dev_q), .dev_oe(dev_oe));

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until the ready edge, then withdraws it.
  task automatic send(input logic [1:0] op, input logic [30:0] a,
                      input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req_op = op; req_addr = a; req_wdata = d;
    req_cmd = d[7:0]; req_len = d[7:0]; req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, req_ready}, 16'h1);
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  // Waits, bounded, for the host to come back to idle.
  task automatic idle;
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk({15'h0, req_ready}, 16'h1);
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset;
    chk({15'h0, ce_n}, 16'h1);
    chk({15'h0, wp_n}, 16'h0);
    chk({15'h0, io_oe}, 16'h0);
  endtask
  // Every command code reaches the part intact on the low lines.
  task automatic t_cmds;
    logic [7:0] codes [21] = '{8'h00, 8'h30, 8'h05, 8'he0, 8'h31, 8'h34,
      8'h80, 8'h85, 8'h35, 8'h10, 8'h15, 8'h60, 8'hd0, 8'hff, 8'h90, 8'h70,
      8'h7a, 8'h23, 8'h24, 8'h2a, 8'h2c};
    req_wp_en = 1'b1;
    foreach (codes[i]) begin
      send(OP_CMD, '0, {8'h00, codes[i]});
      idle();
      chk({8'h0, fbcd_flash_model_inst.cmd_q}, {8'h0, codes[i]});
    end
  endtask
  // Five address cycles packed for a byte-wide 8 Gbit part.
  task automatic t_addr;
    send(OP_CMD, '0, 16'h0000);
    send(OP_ADDR, ADR, 16'h0000);
    idle();
    chk({13'h0, fbcd_flash_model_inst.acnt}, 16'h5);
    chk(fbcd_flash_model_inst.addr_q[15:0],
        {4'h0, ADR[11:8], ADR[7:0]});
    chk(fbcd_flash_model_inst.addr_q[31:16], ADR[27:12]);
    chk({8'h0, fbcd_flash_model_inst.addr_q[39:32]},
        {13'h0, ADR[30:28]});
  endtask
  // Program words land while unprotected, are refused once protected.
  task automatic t_write;
    int base;
    req_wp_en = 1'b1;
    send(OP_CMD, '0, 16'h0080);
    base = fbcd_flash_model_inst.prog_cnt;
    for (int i = 0; i < 3; i++) begin
      send(OP_WR, '0, 16'h5a30 + 16'(i));
      idle();
      chk({8'h0, fbcd_flash_model_inst.prog_q}, 16'h0030 + 16'(i));
    end
    chk(16'(fbcd_flash_model_inst.prog_cnt - base), 16'h3);
    req_wp_en = 1'b0;
    send(OP_WR, '0, 16'h00c3);
    idle();
    chk(16'(fbcd_flash_model_inst.prog_cnt - base), 16'h3);
  endtask
  // Burst longer than the FIFO stalls the bus, then drains in order.
  task automatic t_read;
    int i;
    int n;
    i = 0;
    n = 0;
    send(OP_CMD, '0, 16'h0000);
    send(OP_ADDR, ADR, 16'h0000);
    send(OP_CMD, '0, 16'h0030);
    idle();
    send(OP_RD, '0, 16'd35);
    repeat (600) @(negedge clk);
    chk({15'h0, busy}, 16'h1);
    chk({15'h0, rd_valid}, 16'h1);
    rd_ready = 1'b1;
    while (i < 36 && n < 3000) begin
      if (rd_valid === 1'b1) begin
        chk(rd_data,
            {8'h0, (ADR[7:0] + 8'(i)) ^ 8'ha5});
        i++;
      end
      @(negedge clk);
      n++;
    end
    chk(16'(i), 16'd36);
    idle();
    chk({15'h0, rd_valid}, 16'h0);
  endtask

  // ****************************************************************
  // Verdict, watchdog and main sequence.
  // ****************************************************************
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // The whole run needs about a thousand cycles; this catches a hang.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      print_verdict();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    t_reset();
    rst_n = 1'b1;
    t_cmds();
    t_addr();
    t_write();
    t_read();
    print_verdict();
  end
endmodule
